// ### rtl/spicx_top.sv
// How it works
// - Bit-order bit picks MSB or LSB first.
// - Overrun on unread receive byte; read clears.
// - Complete set after byte; control read clears.
// - Complete reads zero while shifting or disabled.
// - Transmit-empty reads one at reset, when disabled.
// - Buffer write clears empty; load sets it.
// - Transmit-empty and complete drive separate interrupt outputs.
// - Empty interrupt only after first byte loaded.
// - Receive-full set when received byte lands.
// - Reading receive data clears receive-full.
// - Phase zero samples leading, changes trailing.
// - Phase one changes leading, samples trailing.
// - Polarity zero: clock idles low.
// - Polarity one: clock idles high.
// - Enable low stops transfers and empties the buffer; receive data, receive-full and overrun stay readable.
// - Write-only transmit data register at 29h.
// - Read-only receive data register at 2Ah.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "spicx_consts.svh"

module spicx_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ce_i,
  input  wire spicx_pkg::spicx_addr_t addr_i,
  input  wire spicx_pkg::spicx_byte_t wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output spicx_pkg::spicx_byte_t      rdata_o,
  output logic                        sclk_o,
  output logic                        mosi_o,
  input  wire logic                   miso_i,
  output logic                        sel_b_o,
  output logic                        tx_empty_irq_o,
  output logic                        complete_irq_o
);
  import spicx_pkg::*;

  spicx_state_t state_q;
  spicx_byte_t  tx_buf_q;
  spicx_byte_t  rx_data_q;
  spicx_byte_t  rx_shift;
  spicx_byte_t  status;
  logic         lsb_first_q;
  logic         phase_q;
  logic         polarity_q;
  logic         enable_q;
  logic         tx_full_q;
  logic         rx_full_q;
  logic         overrun_q;
  logic         complete_q;
  logic         armed_q;
  logic         miso_s1_q;
  logic         miso_s2_q;
  logic [2:0]   div_q;
  logic [3:0]   edge_q;
  logic         wr_tx;
  logic         wr_ctrl;
  logic         rd_rx;
  logic         rd_ctrl;
  logic         load;
  logic         tick;
  logic         leading;
  logic         advance;
  logic         sample;
  logic         finish;
  logic         tx_empty;

  // Register port decode.
  assign wr_tx   = wr_i && (addr_i == `SPICX_ADDR_TXDATA) && enable_q;
  assign wr_ctrl = wr_i && (addr_i == `SPICX_ADDR_CTRL);
  assign rd_rx   = rd_i && (addr_i == `SPICX_ADDR_RXDATA);
  assign rd_ctrl = rd_i && (addr_i == `SPICX_ADDR_CTRL);

  // A byte moves from the buffer into the shifter only between bytes.
  assign load = enable_q && (state_q == SPICX_IDLE) && tx_full_q;

  // One tick per half serial clock period while a byte is shifting.
  assign tick    = (state_q == SPICX_RUN) && (div_q == `SPICX_DIV_LAST);
  assign leading = !edge_q[0];
  assign finish  = tick && (edge_q == `SPICX_EDGE_LAST);

  // The first bit is presented at load, so the first change edge of
  // phase one and the last change edge of phase zero are skipped.
  always_comb begin
    advance = 1'b0;
    sample  = 1'b0;
    if (tick) begin
      if (phase_q) begin
        advance = leading && (edge_q != `SPICX_EDGE_ZERO);
        sample  = !leading;
      end else begin
        advance = !leading && (edge_q != `SPICX_EDGE_LAST);
        sample  = leading;
      end
    end
  end

  assign tx_empty = !enable_q || !tx_full_q;

  always_comb begin
    status = `SPICX_BYTE_ZERO;
    status[`SPICX_BIT_LSB_FIRST] = lsb_first_q;
    status[`SPICX_BIT_OVERRUN]   = overrun_q;
    status[`SPICX_BIT_COMPLETE]  = complete_q;
    status[`SPICX_BIT_TX_EMPTY]  = tx_empty;
    status[`SPICX_BIT_RX_FULL]   = rx_full_q;
    status[`SPICX_BIT_PHASE]     = phase_q;
    status[`SPICX_BIT_POLARITY]  = polarity_q;
    status[`SPICX_BIT_ENABLE]    = enable_q;
  end

  // Configuration bits are taken on any control write; software is
  // trusted not to change them mid-transfer.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lsb_first_q <= 1'b0;
      phase_q     <= 1'b0;
      polarity_q  <= 1'b0;
      enable_q    <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      lsb_first_q <= wdata_i[`SPICX_BIT_LSB_FIRST];
      phase_q     <= wdata_i[`SPICX_BIT_PHASE];
      polarity_q  <= wdata_i[`SPICX_BIT_POLARITY];
      enable_q    <= wdata_i[`SPICX_BIT_ENABLE];
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= `SPICX_BYTE_ZERO;
    end else if (ce_i) begin
      if (rd_ctrl) begin
        rdata_o <= status;
      end else if (rd_rx) begin
        rdata_o <= rx_data_q;
      end else begin
        rdata_o <= `SPICX_BYTE_ZERO;
      end
    end
  end

  // Transmit buffer; a write in the load cycle keeps the buffer full.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_buf_q  <= `SPICX_BYTE_ZERO;
      tx_full_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_tx) begin
        tx_buf_q <= wdata_i;
      end
      if (!enable_q) begin
        tx_full_q <= 1'b0;
      end else if (wr_tx) begin
        tx_full_q <= 1'b1;
      end else if (load) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // Sequencer.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= SPICX_IDLE;
    end else if (ce_i) begin
      case (state_q)
        SPICX_IDLE: begin
          if (load) begin
            state_q <= SPICX_RUN;
          end
        end
        SPICX_RUN: begin
          if (!enable_q) begin
            state_q <= SPICX_IDLE;
          end else if (finish) begin
            state_q <= SPICX_DONE;
          end
        end
        SPICX_DONE: begin
          state_q <= SPICX_IDLE;
        end
        default: begin
          state_q <= SPICX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_q  <= `SPICX_DIV_ZERO;
      edge_q <= `SPICX_EDGE_ZERO;
    end else if (ce_i) begin
      if (state_q != SPICX_RUN) begin
        div_q  <= `SPICX_DIV_ZERO;
        edge_q <= `SPICX_EDGE_ZERO;
      end else if (tick) begin
        div_q  <= `SPICX_DIV_ZERO;
        edge_q <= edge_q + `SPICX_EDGE_ONE;
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  // Serial clock rests at the polarity level between bytes.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sclk_o <= 1'b0;
    end else if (ce_i) begin
      if (state_q != SPICX_RUN || !enable_q) begin
        sclk_o <= polarity_q;
      end else if (tick) begin
        sclk_o <= !sclk_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_b_o <= 1'b1;
    end else if (ce_i) begin
      sel_b_o <= !(load || (state_q == SPICX_RUN && enable_q));
    end
  end

  // Two flops before anything reads the peer's data pin.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else if (ce_i) begin
      miso_s1_q <= miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end

  spicx_shifter u_shifter (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .load_i      (load),
    .data_i      (tx_buf_q),
    .lsb_first_i (lsb_first_q),
    .advance_i   (advance),
    .sample_i    (sample),
    .serial_i    (miso_s2_q),
    .serial_o    (mosi_o),
    .rx_o        (rx_shift)
  );

  // Receive side: the finished byte lands one cycle after the last edge,
  // so a sample taken on that edge is already in the shifter.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_data_q <= `SPICX_BYTE_ZERO;
      rx_full_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == SPICX_DONE) begin
        rx_data_q <= rx_shift;
        rx_full_q <= 1'b1;
      end else if (rd_rx) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // A byte landing in the cycle that reads the old one is no overrun.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      overrun_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == SPICX_DONE && rx_full_q && !rd_rx) begin
        overrun_q <= 1'b1;
      end else if (rd_ctrl && overrun_q) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      complete_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == SPICX_DONE) begin
        complete_q <= 1'b1;
      end else if (load || !enable_q) begin
        complete_q <= 1'b0;
      end else if (rd_ctrl && complete_q) begin
        complete_q <= 1'b0;
      end
    end
  end

  // The empty interrupt stays quiet until a byte has entered the
  // shifter, although the status bit reads one from enable onward.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      armed_q <= 1'b0;
    end else if (ce_i) begin
      if (!enable_q) begin
        armed_q <= 1'b0;
      end else if (load) begin
        armed_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_empty_irq_o <= 1'b0;
      complete_irq_o <= 1'b0;
    end else if (ce_i) begin
      tx_empty_irq_o <= enable_q && armed_q && !tx_full_q && !wr_tx;
      complete_irq_o <= (state_q == SPICX_DONE) ||
                        (complete_q && !load && enable_q && !(rd_ctrl && complete_q));
    end
  end

endmodule : spicx_top

// ### rtl/spicx_consts.svh
`ifndef SPICX_CONSTS_SVH
`define SPICX_CONSTS_SVH

// Register addresses on the internal register port.
`define SPICX_ADDR_TXDATA   8'h29
`define SPICX_ADDR_RXDATA   8'h2A
`define SPICX_ADDR_CTRL     8'h2B

// Field positions inside the control and status register.
`define SPICX_BIT_LSB_FIRST 7
`define SPICX_BIT_OVERRUN   6
`define SPICX_BIT_COMPLETE  5
`define SPICX_BIT_TX_EMPTY  4
`define SPICX_BIT_RX_FULL   3
`define SPICX_BIT_PHASE     2
`define SPICX_BIT_POLARITY  1
`define SPICX_BIT_ENABLE    0

// Reset values and edge counter constants.
`define SPICX_BYTE_ZERO     8'h00
`define SPICX_DIV_ZERO      3'h0
`define SPICX_EDGE_ZERO     4'h0
`define SPICX_EDGE_ONE      4'h1
`define SPICX_EDGE_LAST     4'hF

// Serial clock timing.
`define SPICX_CLK_PERIOD_NS  25
`define SPICX_SCLK_PERIOD_NS 200
`define SPICX_HALF_CYC ((`SPICX_SCLK_PERIOD_NS / 2) / `SPICX_CLK_PERIOD_NS)
`define SPICX_DIV_LAST 3'(`SPICX_HALF_CYC - 1)

`endif

// ### rtl/spicx_pkg.sv
package spicx_pkg;

  typedef logic [7:0] spicx_addr_t;
  typedef logic [7:0] spicx_byte_t;

  typedef enum logic [1:0] {
    SPICX_IDLE,
    SPICX_RUN,
    SPICX_DONE
  } spicx_state_t;

endpackage : spicx_pkg

// ### rtl/spicx_shifter.sv
`timescale 1ns/1ps
`include "spicx_consts.svh"

module spicx_shifter (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  input  wire logic                  load_i,
  input  wire spicx_pkg::spicx_byte_t data_i,
  input  wire logic                  lsb_first_i,
  input  wire logic                  advance_i,
  input  wire logic                  sample_i,
  input  wire logic                  serial_i,
  output logic                       serial_o,
  output spicx_pkg::spicx_byte_t     rx_o
);
  import spicx_pkg::*;

  spicx_byte_t tx_q;

  // The outgoing bit is held in its own flop so the pin never glitches.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_q     <= `SPICX_BYTE_ZERO;
      serial_o <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        tx_q     <= data_i;
        serial_o <= lsb_first_i ? data_i[0] : data_i[7];
      end else if (advance_i) begin
        if (lsb_first_i) begin
          tx_q     <= {1'b0, tx_q[7:1]};
          serial_o <= tx_q[1];
        end else begin
          tx_q     <= {tx_q[6:0], 1'b0};
          serial_o <= tx_q[6];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_o <= `SPICX_BYTE_ZERO;
    end else if (ce_i && sample_i) begin
      if (lsb_first_i) begin
        rx_o <= {serial_i, rx_o[7:1]};
      end else begin
        rx_o <= {rx_o[6:0], serial_i};
      end
    end
  end

endmodule : spicx_shifter

// ### verif/spicx_checker.sv
`timescale 1ns/1ps
module spicx_checker (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   ce_i,
  input wire spicx_pkg::spicx_addr_t addr_i,
  input wire spicx_pkg::spicx_byte_t wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire spicx_pkg::spicx_byte_t rdata_o,
  input wire logic                   sclk_o,
  input wire logic                   mosi_o,
  input wire logic                   miso_i,
  input wire logic                   sel_b_o,
  input wire logic                   tx_empty_irq_o,
  input wire logic                   complete_irq_o
);
  import spicx_pkg::*;
  logic [3:0] cfg_q;
  logic       sent_q;
  logic       sclk_p_q;
  logic [4:0] edges_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) cfg_q <= 4'h0;
    else if (ce_i && wr_i && addr_i == 8'h2B) cfg_q <= {wdata_i[7], wdata_i[2:0]};
  end
  // Mirrors the arming of the empty interrupt: first accepted byte after enable.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) sent_q <= 1'h0;
    else if (wr_i && addr_i == 8'h2B && !wdata_i[0]) sent_q <= 1'h0;
    else if (wr_i && addr_i == 8'h29 && cfg_q[0]) sent_q <= 1'h1;
  end
  always_ff @(posedge clk_i) begin
    sclk_p_q <= sclk_o;
    if (sel_b_o) edges_q <= 5'h00;
    else if (sclk_o != sclk_p_q) edges_q <= edges_q + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_idle_level: assert property (sel_b_o && $past(sel_b_o, 2) && cfg_q[1] == $past(cfg_q[1], 2)
    |-> sclk_o == cfg_q[1]) else $error("serial clock not at idle level");
  a_read_zero: assert property ($past(!(rd_i && (addr_i == 8'h2A || addr_i == 8'h2B)))
    |-> rdata_o == 8'h00) else $error("read data not zero");
  a_cfg_readback: assert property ($past(rd_i && addr_i == 8'h2B)
    |-> {rdata_o[7], rdata_o[2:0]} == $past(cfg_q)) else $error("config bits read wrong");
  a_event_clear: assert property ((rd_i && addr_i == 8'h2B) ##1
    (rd_i && addr_i == 8'h2B && rdata_o[6:5] != 2'h0) |=> rdata_o[6:5] == 2'h0)
    else $error("event flags not cleared by read");
  a_rx_clear: assert property ((rd_i && addr_i == 8'h2A) ##1 (rd_i && addr_i == 8'h2B)
    |=> !rdata_o[3]) else $error("receive full not cleared");
  a_empty_off: assert property ($past(rd_i && addr_i == 8'h2B && !cfg_q[0]) |-> rdata_o[4])
    else $error("transmit empty low while disabled");
  a_edge_count: assert property ($rose(sel_b_o) && cfg_q[0] |-> edges_q == 5'h10)
    else $error("frame without sixteen clock edges");
  a_irq_armed: assert property (!sent_q && $past(!sent_q) |-> !tx_empty_irq_o)
    else $error("empty interrupt before first byte");
  a_cirq_mirror: assert property ($past(rd_i && addr_i == 8'h2B)
    |-> rdata_o[5] == $past(complete_irq_o)) else $error("complete interrupt differs from flag");
  c_frame: cover property ($rose(sel_b_o));
  c_irq: cover property (tx_empty_irq_o);
  c_overrun: cover property (rd_i && addr_i == 8'h2B ##1 rdata_o[6]);
endmodule : spicx_checker
bind spicx_top spicx_checker spicx_checker_inst (.*);

// ### verif/spicx_peer.sv
`timescale 1ns/1ps
module spicx_peer (
  input  wire logic                   sclk_i,
  input  wire logic                   mosi_i,
  input  wire logic                   sel_b_i,
  input  wire logic                   phase_i,
  input  wire logic                   lsb_first_i,
  input  wire spicx_pkg::spicx_byte_t reply_i,
  output logic                        miso_o,
  output spicx_pkg::spicx_byte_t      got_o
);
  import spicx_pkg::*;
  int unsigned edge_n;
  int unsigned bit_n;
  function automatic logic pick(input int unsigned k);
    return lsb_first_i ? reply_i[k % 8] : reply_i[7 - k % 8];
  endfunction : pick
  initial begin
    miso_o = 1'h0;
    got_o = 8'h00;
  end
  always @(negedge sel_b_i) begin
    edge_n = 0;
    bit_n = phase_i ? 0 : 1;
    miso_o = phase_i ? ~pick(0) : pick(0);
  end
  // Nothing pulls the released line, so it must not keep a plausible level.
  always @(posedge sel_b_i) miso_o = ~miso_o;
  always @(sclk_i) begin
    if (!sel_b_i) begin
      edge_n++;
      if (edge_n[0] ^ phase_i) got_o = lsb_first_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
      else begin
        miso_o = pick(bit_n);
        bit_n++;
      end
    end
  end
endmodule : spicx_peer

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import spicx_pkg::*;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        lsb = 1'h0;
  logic        phase = 1'h0;
  spicx_addr_t addr = 8'h00;
  spicx_byte_t wdata = 8'h00;
  spicx_byte_t reply = 8'h00;
  spicx_byte_t rdata, got, seed, b1, b2, d, e, z;
  logic        sclk, mosi, miso, sel_b, irq, cirq;
  int          n_fail = 0;
  int          comparisons = 0;
  always #12.5 clk = ~clk;
  spicx_top spicx_top_inst (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'h1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sclk_o(sclk), .mosi_o(mosi),
    .miso_i(miso), .sel_b_o(sel_b), .tx_empty_irq_o(irq), .complete_irq_o(cirq));
  spicx_peer spicx_peer_inst (.sclk_i(sclk), .mosi_i(mosi), .sel_b_i(sel_b), .phase_i(phase),
    .lsb_first_i(lsb), .reply_i(reply), .miso_o(miso), .got_o(got));
  function automatic spicx_byte_t lfsr(input spicx_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Flags f are overrun, complete, transmit empty, receive full; enable is set.
  function automatic spicx_byte_t status(input logic [2:0] cfg, input logic [3:0] f);
    return {cfg[2], f, cfg[1:0], 1'h1};
  endfunction : status
  task automatic check(input spicx_byte_t seen, input spicx_byte_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr_reg(input spicx_addr_t a, input spicx_byte_t v);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask : wr_reg
  // Two reads with no gap; each result is taken in the one cycle where it stands.
  task automatic rd2(input spicx_addr_t a1, input spicx_addr_t a2, output spicx_byte_t d1,
                     output spicx_byte_t d2);
    rd <= 1'h1;
    addr <= a1;
    @(posedge clk);
    addr <= a2;
    @(posedge clk);
    rd <= 1'h0;
    d1 = rdata;
    @(posedge clk);
    d2 = rdata;
  endtask : rd2
  task automatic rd_reg(input spicx_addr_t a, output spicx_byte_t v);
    rd2(a, 8'h77, v, z);
    check(z, 8'h00);
  endtask : rd_reg
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3000) begin
      @(posedge clk);
      n = sel_b ? n + 1 : 0;
      if (n == 8) return;
    end
    n_fail++;
    finish_test;
  endtask : wait_idle
  initial begin
    seed = 8'h30;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd_reg(8'h2B, d);
    check(d, 8'h10);
    rd_reg(8'h29, d);
    check(d, 8'h00);
    wr_reg(8'h29, 8'h5A);
    rd_reg(8'h2B, d);
    check(d, 8'h10);
    wr_reg(8'h2A, 8'hFF);
    rd_reg(8'h2A, d);
    check(d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      lsb = c[2];
      phase = c[1];
      seed = lfsr(seed);
      b1 = seed;
      seed = lfsr(seed);
      b2 = seed;
      seed = lfsr(seed);
      reply = seed;
      wr_reg(8'h2B, 8'h00);
      wr_reg(8'h2B, {c[2], 4'h0, c[1:0], 1'h1});
      @(posedge clk);
      check(8'(sclk), 8'(c[0]));
      check(8'(irq), 8'h00);
      check(8'(cirq), 8'h00);
      wr_reg(8'h29, b1);
      wr_reg(8'h29, b2);
      rd_reg(8'h2B, d);
      check(d, status(c[2:0], 4'h0));
      wait_idle;
      check(got, b2);
      check(8'(irq), 8'h01);
      check(8'(cirq), 8'h01);
      rd2(8'h2B, 8'h2B, d, e);
      check(d, status(c[2:0], 4'hF));
      check(e, status(c[2:0], 4'h3));
      check(8'(cirq), 8'h00);
      rd2(8'h2A, 8'h2B, d, e);
      check(d, reply);
      check(e, status(c[2:0], 4'h2));
    end
    wr_reg(8'h29, b1);
    repeat (20) @(posedge clk);
    wr_reg(8'h2B, 8'h86);
    @(posedge clk);
    check({6'h00, sel_b, sclk}, 8'h03);
    rd_reg(8'h2B, d);
    check(d, 8'h96);
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule : testbench
